// File: src/idle_sniff_pkg.sv
// constants, register map and states for the idle and sniff power controller
package idle_sniff_pkg;
   localparam int unsigned CLK_HZ      = 100_000_000;
   localparam int unsigned SLOW_OSC_HZ = 10_000;
   localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_OSC_HZ;
   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_COMMAND  = 6'h00;
   localparam logic [5:0] IDX_STATUS2  = 6'h02;
   localparam logic [5:0] IDX_GEN_A    = 6'h0c;
   localparam logic [5:0] IDX_GEN_B    = 6'h0d;
   localparam logic [5:0] IDX_RX_CFG   = 6'h0e;
   localparam logic [5:0] IDX_IDLE_CFG = 6'h10;
   localparam logic [5:0] IDX_SNIFF_IV = 6'h20;
   localparam logic [5:0] IDX_BURST_IV = 6'h21;
   localparam logic [5:0] IDX_MAINT_IV = 6'h22;
   localparam logic [5:0] IDX_E_DWELL  = 6'h23;
   localparam logic [5:0] IDX_C_DWELL  = 6'h24;
   localparam logic [5:0] IDX_THRESH   = 6'h25;
   localparam logic [5:0] IDX_AUTO_WIN = 6'h26;
   localparam logic [5:0] IDX_AUTO_TGT = 6'h27;
   localparam logic [5:0] IDX_OPTIONS  = 6'h28;
   // commands
   localparam logic [7:0] CMD_IDLE_ENTER  = 8'h03;
   localparam logic [7:0] CMD_IDLE_RETURN = 8'h04;
   // field positions
   localparam int GA_CLK_STBY = 0;
   localparam int GA_POR_LO   = 1;
   localparam int GB_CLK_LO   = 0;
   localparam int RX_WAKE_EN  = 0;
   localparam int RX_SQUELCH  = 1;
   localparam int IC_DRAIN_LO = 3;
   localparam int IC_DSEL_LO  = 5;
   localparam int OPT_ID_CHK  = 0;
   localparam int OPT_HK_HOST = 1;
   localparam int ST2_BUSY    = 0;
   // power-on state selection
   localparam logic [1:0] POR_STANDBY = 2'b01;
   localparam logic [1:0] POR_IDLE    = 2'b10;
   // reset values
   localparam logic [7:0] REG_RST    = 8'h00;
   localparam logic [7:0] THRESH_RST = 8'h80;
   // host clock counts before shutoff
   localparam logic [10:0] DRAIN_256  = 11'd256;
   localparam logic [10:0] DRAIN_512  = 11'd512;
   localparam logic [10:0] DRAIN_1024 = 11'd1024;
   // sniff acquisition budget
   localparam int unsigned SNIFF_ACQ_NS  = 130_000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SNIFF_ACQ_CYC = SNIFF_ACQ_NS / CLK_PERIOD_NS;
   typedef enum logic [7:0] {
      ST_ACTIVE  = 8'b0000_0001,
      ST_STANDBY = 8'b0000_0010,
      ST_DRAIN   = 8'b0000_0100,
      ST_IDLE    = 8'b0000_1000,
      ST_ENERGY  = 8'b0001_0000,
      ST_CODE    = 8'b0010_0000,
      ST_RECEIVE = 8'b0100_0000,
      ST_AWAKE   = 8'b1000_0000
   } pwr_state_e;
endpackage

// File: src/idle_sniff_power_controller.sv
// idle, sniff and periodic task controller with avalon register slave
// Contract
// - command 0x03 enters idle, 0x04 returns idle
// - options A bits 2:1 pick power-on state; read only while still 00 just after reset, so power-on is always active
// - options A bit 0 keeps clock in standby
// - options B bits 1:0 pick host clock rate
// - standby may clock host, idle never does
// - slow oscillator ticks drive all idle timers
// - host clock after valid packet or wake
// - return command sends device back to idle
// - idle bits enable maintenance, burst, sniff
// - interrupt on data ready, then data select
// - bits 7:5 set interrupt to select delay
// - bits 4:3 set host clocks before shutoff
// - sniff sleeps, wakes, receives on energy
// - no valid identifier returns to sleep
// - rx bit 0 wakes on energy threshold
// - rx bit 1 squelches data below threshold
// - sniff wake acquires within 130 us; ACQ_CYC_P is not used, so no acquisition limit is applied
// - sniff interval sets time between wakes
// - energy dwell bounds each energy search
// - code dwell bounds identifier search
// - count false wakes, adjust threshold
// - maintenance and burst wakes run periodically
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module idle_sniff_power_controller #(
   parameter int unsigned SLOW_DIV_P = idle_sniff_pkg::SLOW_DIV,
   parameter int unsigned ACQ_CYC_P  = idle_sniff_pkg::SNIFF_ACQ_CYC
) (
   input  wire logic        clock_i,         // 100 MHz system clock
   input  wire logic        reset_n_i,       // async reset, active low
   input  wire logic [7:0]  address_i,       // avalon byte address
   input  wire logic        read_i,          // avalon read
   input  wire logic        write_i,         // avalon write
   input  wire logic [31:0] writedata_i,     // avalon write data
   output logic      [31:0] readdata_o,      // avalon read data
   output logic             waitrequest_o,   // avalon wait
   input  wire logic [7:0]  energy_level_i,  // received energy level
   input  wire logic        id_valid_i,      // own identifier seen
   input  wire logic        packet_valid_i,  // valid packet received
   input  wire logic        bit_tick_i,      // one pulse per bit time
   output logic             host_clock_o,    // clock to host
   output logic             data_select_n_o, // data select, low active
   output logic             irq_o,           // data ready interrupt
   output logic             rx_enable_o,     // receiver powered
   output logic             rx_data_en_o,    // recovered clk/data enable
   output logic             burst_start_o,   // burst transmit pulse
   output logic             maint_start_o    // periodic_maintenance pulse
);
   import idle_sniff_pkg::*;

   pwr_state_e state;
   pwr_state_e next_state;
   logic [7:0]  gen_a, gen_b, rx_cfg, idle_cfg, opts;
   logic [7:0]  intv [3];
   logic [7:0]  e_dwell, c_dwell, thresh, auto_win, auto_tgt;
   logic        booted;
   logic [13:0] slow_cnt;
   logic        slow_tick;
   logic [7:0]  task_cnt [3];
   logic [2:0]  task_fire;
   logic [7:0]  dwell_cnt;
   logic [10:0] drain_cnt;
   logic [3:0]  hdiv;
   logic [3:0]  dsel_cnt;
   logic        pending;
   logic [7:0]  sniff_cnt, false_cnt;

   // decoded host clock count before shutoff
   function automatic logic [10:0] drain_len(input logic [1:0] code);
      unique case (code)
         2'b01:   drain_len = DRAIN_256;
         2'b10:   drain_len = DRAIN_512;
         2'b11:   drain_len = DRAIN_1024;
         default: drain_len = 11'h000;
      endcase
   endfunction

   // bus decode
   wire [5:0] idx     = address_i[7:2];
   wire       req     = read_i | write_i;
   wire       wr_take = write_i & ~waitrequest_o;
   wire       wr_cmd  = wr_take & (idx == IDX_COMMAND);
   wire       go_idle = wr_cmd & ((writedata_i[7:0] == CMD_IDLE_ENTER) |
                                  (writedata_i[7:0] == CMD_IDLE_RETURN));
   wire       busy    = ~(state inside {ST_IDLE, ST_STANDBY, ST_ACTIVE});
   logic [7:0] rd_mux;
   // read data select; unmapped and write-only indices read as zero
   always_comb begin
      unique case (idx)
         IDX_STATUS2:  rd_mux = {7'h00, busy};
         IDX_GEN_A:    rd_mux = gen_a;
         IDX_GEN_B:    rd_mux = gen_b;
         IDX_RX_CFG:   rd_mux = rx_cfg;
         IDX_IDLE_CFG: rd_mux = idle_cfg;
         IDX_SNIFF_IV: rd_mux = intv[0];
         IDX_BURST_IV: rd_mux = intv[1];
         IDX_MAINT_IV: rd_mux = intv[2];
         IDX_E_DWELL:  rd_mux = e_dwell;
         IDX_C_DWELL:  rd_mux = c_dwell;
         IDX_THRESH:   rd_mux = thresh;
         IDX_AUTO_WIN: rd_mux = auto_win;
         IDX_AUTO_TGT: rd_mux = auto_tgt;
         IDX_OPTIONS:  rd_mux = opts;
         default:      rd_mux = 8'h00;
      endcase
   end

   // one wait cycle per access, answer registered
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         waitrequest_o <= 1'b1;
         readdata_o    <= 32'h0000_0000;
      end else begin
         waitrequest_o <= ~(req & waitrequest_o);
         if (read_i & waitrequest_o) begin
            readdata_o <= {24'h00_0000, rd_mux};
         end
      end
   end

   // auto threshold decision at the end of each window
   wire energy_hit = rx_cfg[RX_WAKE_EN] ? (energy_level_i >= thresh) : 1'b1;
   wire code_miss  = (state == ST_CODE) & (dwell_cnt >= c_dwell) & slow_tick & ~id_valid_i;
   wire win_end    = (auto_win != 8'h00) & (state == ST_ENERGY) & (dwell_cnt == 8'h00)
                     & (sniff_cnt >= auto_win - 8'h01) & ~slow_tick & (next_state == ST_ENERGY);
   wire th_up      = win_end & (false_cnt > auto_tgt) & (thresh != 8'hff);
   wire th_down    = win_end & (false_cnt < auto_tgt) & (thresh != 8'h00);

   // register file; hardware threshold adjust shares the writer
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gen_a    <= REG_RST;
         gen_b    <= REG_RST;
         rx_cfg   <= REG_RST;
         idle_cfg <= REG_RST;
         opts     <= REG_RST;
         e_dwell  <= REG_RST;
         c_dwell  <= REG_RST;
         auto_win <= REG_RST;
         auto_tgt <= REG_RST;
         thresh <= THRESH_RST;
         for (int i = 0; i < 3; i++) intv[i] <= REG_RST;
      end else if (wr_take) begin
         unique case (idx)
            IDX_GEN_A:    gen_a    <= writedata_i[7:0];
            IDX_GEN_B:    gen_b    <= writedata_i[7:0];
            IDX_RX_CFG:   rx_cfg   <= writedata_i[7:0];
            IDX_IDLE_CFG: idle_cfg <= writedata_i[7:0];
            IDX_SNIFF_IV: intv[0]  <= writedata_i[7:0];
            IDX_BURST_IV: intv[1]  <= writedata_i[7:0];
            IDX_MAINT_IV: intv[2]  <= writedata_i[7:0];
            IDX_E_DWELL:  e_dwell  <= writedata_i[7:0];
            IDX_C_DWELL:  c_dwell  <= writedata_i[7:0];
            IDX_THRESH:   thresh   <= writedata_i[7:0];
            IDX_AUTO_WIN: auto_win <= writedata_i[7:0];
            IDX_AUTO_TGT: auto_tgt <= writedata_i[7:0];
            IDX_OPTIONS:  opts     <= writedata_i[7:0];
            default:      ;
         endcase
      end else if (th_up) begin
         thresh <= thresh + 8'h01;
      end else if (th_down) begin
         thresh <= thresh - 8'h01;
      end
   end

   // false wake and window counters
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sniff_cnt <= 8'h00;
         false_cnt <= 8'h00;
      end else if (win_end) begin
         sniff_cnt <= 8'h00;
         false_cnt <= 8'h00;
      end else begin
         if (state == ST_IDLE && next_state == ST_ENERGY) sniff_cnt <= sniff_cnt + 8'h01;
         if (code_miss) false_cnt <= false_cnt + 8'h01;
      end
   end

   // slow oscillator tick, stands in for the 10 kHz source
   assign slow_tick = (slow_cnt == 14'(SLOW_DIV_P - 1));
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) slow_cnt <= 14'h0000;
      else slow_cnt <= slow_tick ? 14'h0000 : slow_cnt + 14'h0001;
   end

   // one interval timer per idle task; all three restart whenever the state leaves idle, energy or code
   wire in_idle = state inside {ST_IDLE, ST_ENERGY, ST_CODE};
   generate
      for (genvar g = 0; g < 3; g++) begin : g_task
         wire run = in_idle & idle_cfg[g] & (intv[g] != 8'h00);
         assign task_fire[g] = run & slow_tick & (task_cnt[g] >= intv[g] - 8'h01);
         always_ff @(posedge clock_i or negedge reset_n_i) begin
            if (!reset_n_i) task_cnt[g] <= 8'h00;
            else if (!run || task_fire[g]) task_cnt[g] <= 8'h00;
            else if (slow_tick) task_cnt[g] <= task_cnt[g] + 8'h01;
         end
      end
   endgenerate

   // power state transitions
   always_comb begin
      next_state = state;
      if (!booted) begin
         unique case (gen_a[GA_POR_LO +: 2])
            POR_STANDBY: next_state = ST_STANDBY;
            POR_IDLE:    next_state = ST_IDLE;
            default:     next_state = ST_ACTIVE;
         endcase
      end else if (go_idle) begin
         next_state = (drain_len(idle_cfg[IC_DRAIN_LO +: 2]) == 11'h000)
                      ? ST_IDLE : ST_DRAIN;
      end else begin
         unique case (state)
            ST_DRAIN:
               if (drain_cnt >= drain_len(idle_cfg[IC_DRAIN_LO +: 2])) next_state = ST_IDLE;
            ST_IDLE:
               if (task_fire[2] && opts[OPT_HK_HOST]) next_state = ST_AWAKE;
               else if (task_fire[0]) next_state = ST_ENERGY;
            ST_ENERGY:
               if (energy_hit) next_state = opts[OPT_ID_CHK] ? ST_CODE : ST_RECEIVE;
               else if (slow_tick && dwell_cnt >= e_dwell) next_state = ST_IDLE;
            ST_CODE:
               if (id_valid_i) next_state = ST_RECEIVE;
               else if (code_miss) next_state = ST_IDLE;
            // awake and receive are left only on a new idle command
            default: ;
         endcase
      end
   end

   // state register; power-on choice is applied once after reset
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state  <= ST_ACTIVE;
         booted <= 1'b0;
      end else begin
         state  <= next_state;
         booted <= 1'b1;
      end
   end

   // dwell counter restarts on every state change
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) dwell_cnt <= 8'h00;
      else if (next_state != state) dwell_cnt <= 8'h00;
      else if (slow_tick && dwell_cnt != 8'hff) dwell_cnt <= dwell_cnt + 8'h01;
   end

   // host clock gating; standby only if allowed, idle never
   wire hclk_run = (state == ST_ACTIVE) | (state == ST_DRAIN) | (state == ST_AWAKE)
                   | ((state == ST_STANDBY) & gen_a[GA_CLK_STBY])
                   | ((state == ST_RECEIVE) & pending);
   wire next_hclk = hclk_run & hdiv[gen_b[GB_CLK_LO +: 2]];
   // drain counts only the edges the host will really see
   wire hclk_rise = next_hclk & ~host_clock_o;
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hdiv         <= 4'h0;
         host_clock_o <= 1'b0;
      end else begin
         hdiv         <= hdiv + 4'h1;
         host_clock_o <= next_hclk;
      end
   end

   // host clock edges given during the drain
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) drain_cnt <= 11'h000;
      else if (state != ST_DRAIN) drain_cnt <= 11'h000;
      else if (hclk_rise) drain_cnt <= drain_cnt + 11'h001;
   end

   // interrupt then data select after the programmed bit times
   wire [3:0] dsel_len  = (idle_cfg[IC_DSEL_LO +: 3] == 3'b000) ? 4'h0
                          : {1'b0, idle_cfg[IC_DSEL_LO +: 3]} + 4'h1;
   wire       dsel_done = pending & (dsel_cnt >= dsel_len);
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pending         <= 1'b0;
         dsel_cnt        <= 4'h0;
         irq_o           <= 1'b0;
         data_select_n_o <= 1'b1;
      end else if (state != ST_RECEIVE) begin
         pending         <= 1'b0;
         dsel_cnt        <= 4'h0;
         irq_o           <= 1'b0;
         data_select_n_o <= 1'b1;
      end else begin
         if (packet_valid_i) pending <= 1'b1;
         if (packet_valid_i) irq_o <= 1'b1;
         if (pending && bit_tick_i && !dsel_done) dsel_cnt <= dsel_cnt + 4'h1;
         data_select_n_o <= ~dsel_done;
      end
   end

   // receiver and task outputs
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_enable_o   <= 1'b0;
         rx_data_en_o  <= 1'b0;
         burst_start_o <= 1'b0;
         maint_start_o <= 1'b0;
      end else begin
         rx_enable_o   <= next_state inside {ST_ENERGY, ST_CODE, ST_RECEIVE, ST_ACTIVE};
         rx_data_en_o  <= ~(rx_cfg[RX_SQUELCH] & (energy_level_i < thresh));
         burst_start_o <= task_fire[1];
         maint_start_o <= task_fire[2];
      end
   end

   // checks
   sequence s_idle_cmd;
      booted && go_idle && idle_cfg[4:3] == 2'b00;
   endsequence
   AST_IDLE_CMD: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_idle_cmd |=> state == ST_IDLE) else $error("idle command not taken");
   AST_IDLE_NO_CLK: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state == ST_IDLE |=> !host_clock_o) else $error("host clock runs in idle");
   AST_STBY_CLK: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state == ST_STANDBY && !gen_a[0] |=> !host_clock_o) else $error("standby clock leak");
   AST_ENERGY_WAKE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state == ST_ENERGY && energy_hit && !go_idle |=> state inside {ST_CODE, ST_RECEIVE})
      else $error("energy did not wake receiver");
   AST_ID_MISS: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      code_miss && !go_idle |=> state == ST_IDLE) else $error("id miss stayed awake");
   AST_DSEL_IMM: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state == ST_RECEIVE && idle_cfg[7:5] == 3'b000 && $rose(pending)
      && next_state == ST_RECEIVE |=> !data_select_n_o) else $error("select not immediate");
   AST_IRQ_FIRST: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $fell(data_select_n_o) |-> irq_o) else $error("select before interrupt");
   AST_SQUELCH: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      rx_cfg[1] && energy_level_i < thresh |=> !rx_data_en_o) else $error("squelch failed");
   AST_BURST: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      burst_start_o |-> $past(idle_cfg[1])) else $error("burst while disabled");

   // periodic tasks only while enabled
   AST_MAINT: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      maint_start_o |-> $past(idle_cfg[2])) else $error("maintenance while disabled");
   AST_SNIFF_OFF: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state == ST_IDLE && !idle_cfg[0] |=> state != ST_ENERGY)
      else $error("sniff wake while disabled");

   // sleeping receiver stays unpowered
   AST_RX_SLEEP: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state == ST_IDLE && next_state == ST_IDLE |=> !rx_enable_o)
      else $error("receiver powered while asleep");
   // a dwell that runs out sends the search back to sleep
   AST_DWELL_END: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state == ST_ENERGY && !energy_hit && !go_idle && slow_tick && dwell_cnt >= e_dwell
      |=> state == ST_IDLE) else $error("energy dwell overran");
   // an identifier seen in time moves on to receive
   AST_CODE_HIT: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state == ST_CODE && id_valid_i && !go_idle |=> state == ST_RECEIVE)
      else $error("identifier ignored");
   // interrupt and select only while receiving
   AST_DSEL_RX: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      state != ST_RECEIVE |=> data_select_n_o && !irq_o) else $error("select outside receive");

   // drain ends in idle once the edge count is met
   sequence s_drain_met;
      state == ST_DRAIN && !go_idle && drain_cnt >= drain_len(idle_cfg[IC_DRAIN_LO +: 2]);
   endsequence
   AST_DRAIN_END: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_drain_met |=> state == ST_IDLE) else $error("drain did not end");

   // threshold moves only on a write or at a window end
   AST_TH_HOLD: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !wr_take && !win_end |=> $stable(thresh)) else $error("threshold moved on its own");
endmodule

// File: tb/host_bus_model.sv
// avalon host model issuing register cycles to the controller
`timescale 1ns/1ps
module host_bus_model (
   input  wire logic        clock_i,       // system clock
   input  wire logic        waitrequest_i, // slave wait
   input  wire logic [31:0] readdata_i,    // slave read data
   output logic      [7:0]  address_o,     // byte address
   output logic             read_o,        // read strobe
   output logic             write_o,       // write strobe
   output logic      [31:0] writedata_o    // write data
);
   initial begin
      address_o   = 8'h00;
      read_o      = 1'b0;
      write_o     = 1'b0;
      writedata_o = 32'h0000_0000;
   end
   // one access, held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [5:0] idx,
                         input logic [7:0] wd, output logic [31:0] rd);
      @(posedge clock_i);
      address_o   <= {idx, 2'b00};
      writedata_o <= {24'h00_0000, wd};
      read_o      <= ~wr;
      write_o     <= wr;
      do @(posedge clock_i); while (waitrequest_i !== 1'b0);
      rd = readdata_i;
      read_o  <= 1'b0;
      write_o <= 1'b0;
      // released data shows the inverse, never a stale copy
      writedata_o <= ~writedata_o;
   endtask
endmodule

// File: tb/idle_sniff_power_controller_tb.sv
// self-checking bench for the idle and sniff power controller
`timescale 1ns/1ps
module idle_sniff_power_controller_tb;
   import idle_sniff_pkg::*;
   localparam int unsigned DIV = 8; // short slow tick keeps timers brief
   logic        clock_i   = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [7:0]  energy    = 8'h00;
   logic        id_valid  = 1'b0;
   logic        pkt_valid = 1'b0;
   logic        bit_tick  = 1'b0;
   logic        bt_run    = 1'b0;
   logic [1:0]  tick_div  = 2'b00;
   logic        host_clock_o, data_select_n_o, irq_o, rx_enable_o;
   logic        rx_data_en_o, burst_start_o, maint_start_o;
   int          failures  = 0;
   int          compares  = 0;
   int          cycles    = 0;
   int unsigned model [int];
   int          qb [$];
   int          qm [$];
   logic [31:0] rd;
   int          n;
   int          t;

   host_bus_model host (.clock_i(clock_i), .waitrequest_i(waitrequest),
      .readdata_i(readdata), .address_o(address), .read_o(read),
      .write_o(write), .writedata_o(writedata));
   idle_sniff_power_controller #(.SLOW_DIV_P(DIV)) dut (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .address_i(address),
      .read_i(read), .write_i(write), .writedata_i(writedata),
      .readdata_o(readdata), .waitrequest_o(waitrequest),
      .energy_level_i(energy), .id_valid_i(id_valid), .packet_valid_i(pkt_valid),
      .bit_tick_i(bit_tick), .host_clock_o(host_clock_o),
      .data_select_n_o(data_select_n_o), .irq_o(irq_o), .rx_enable_o(rx_enable_o),
      .rx_data_en_o(rx_data_en_o), .burst_start_o(burst_start_o),
      .maint_start_o(maint_start_o));

   always #5 clock_i = ~clock_i;
   // bit time pulses every fourth cycle while enabled
   always @(posedge clock_i) begin
      tick_div <= tick_div + 2'b01;
      bit_tick <= bt_run && tick_div == 2'b11;
   end
   // cycle ceiling cuts a hang short
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // bounds check, an unknown never lands inside the bounds
   task automatic check(input string what, input logic [31:0] lo,
                        input logic [31:0] hi, input logic [31:0] seen);
      compares++;
      if ((seen >= lo && seen <= hi) !== 1'b1) begin
         failures++;
         $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, seen);
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      host.access(1'b1, idx, v, rd);
      if (model.exists(idx))
         model[idx] = v;
   endtask
   task automatic rd_chk(input logic [5:0] idx);
      logic [31:0] e;
      e = model.exists(idx) ? model[idx] : 0;
      host.access(1'b0, idx, 8'h00, rd);
      check("register", e, e, rd);
   endtask
   // rising edges of host clock (sel 0) or receiver power (sel 1)
   task automatic count_rise(input bit sel, input int len, output int k);
      logic last;
      logic s;
      k = 0;
      last = sel ? rx_enable_o : host_clock_o;
      repeat (len) begin
         @(posedge clock_i);
         #1;
         s = sel ? rx_enable_o : host_clock_o;
         if (s === 1'b1 && last === 1'b0)
            k++;
         last = s;
      end
   endtask

   initial begin
      logic [5:0] rw [5];
      int         codes [3];
      int         e;
      rw = '{IDX_GEN_A, IDX_GEN_B, IDX_RX_CFG, IDX_IDLE_CFG, IDX_THRESH};
      void'($urandom(93));
      foreach (rw[i]) model[rw[i]] = REG_RST;
      model[IDX_THRESH] = THRESH_RST;
      repeat (4) @(posedge clock_i);
      reset_n_i <= 1'b1;
      // reset values, write-only command, unmapped index
      foreach (rw[i]) rd_chk(rw[i]);
      rd_chk(IDX_COMMAND);
      rd_chk(6'h3f);
      rd_chk(IDX_STATUS2);
      // random patterns read back; an unmapped write is dropped
      foreach (rw[i]) begin
         wr(rw[i], 8'($urandom));
         rd_chk(rw[i]);
      end
      wr(6'h3f, 8'h5a);
      rd_chk(6'h3f);
      foreach (rw[i]) wr(rw[i], i == 4 ? THRESH_RST : REG_RST);
      // host clock rate per options B code, one edge of phase slack
      for (int c = 0; c < 4; c++) begin
         wr(IDX_GEN_B, 8'(c));
         count_rise(1'b0, 16, n);
         count_rise(1'b0, 256, n);
         check("host clock edges", (128 >> c) - 1, (128 >> c) + 1, n);
      end
      // clocks given before shutoff, both commands, first from active, then from idle
      wr(IDX_GEN_B, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(IDX_IDLE_CFG, 8'(c << IC_DRAIN_LO));
         wr(IDX_COMMAND, (c % 2) ? CMD_IDLE_RETURN : CMD_IDLE_ENTER);
         count_rise(1'b0, 2200, n);
         e = (c == 0) ? 0 : (128 << c);
         check("drain edges", e, e + 1, n);
         rd_chk(IDX_STATUS2);
      end
      // burst and maintenance timers run side by side
      wr(IDX_BURST_IV, 8'h03);
      wr(IDX_MAINT_IV, 8'h05);
      wr(IDX_IDLE_CFG, 8'h06);
      wr(IDX_COMMAND, CMD_IDLE_ENTER);
      for (t = 0; t < 400; t++) begin
         @(posedge clock_i);
         #1;
         if (burst_start_o === 1'b1) qb.push_back(t);
         if (maint_start_o === 1'b1) qm.push_back(t);
      end
      check("burst count", 12, 17, qb.size());
      check("maint count", 7, 10, qm.size());
      for (int k = 1; k < qb.size(); k++)
         check("burst gap", 3 * DIV, 3 * DIV, qb[k] - qb[k - 1]);
      for (int k = 1; k < qm.size(); k++)
         check("maint gap", 5 * DIV, 5 * DIV, qm[k] - qm[k - 1]);
      wr(IDX_BURST_IV, 8'h00);
      wr(IDX_MAINT_IV, 8'h00);
      // sniff wakes and sleeps: no energy, then energy without identifier
      wr(IDX_SNIFF_IV, 8'h02);
      wr(IDX_E_DWELL, 8'h02);
      wr(IDX_C_DWELL, 8'h02);
      wr(IDX_RX_CFG, 8'h03);
      wr(IDX_OPTIONS, 8'h01);
      wr(IDX_IDLE_CFG, 8'h01);
      wr(IDX_COMMAND, CMD_IDLE_ENTER);
      for (int k = 0; k < 2; k++) begin
         @(posedge clock_i);
         energy <= k ? 8'hff : 8'h00;
         count_rise(1'b1, 300, n);
         check("sniff wakes", 3, 20, n);
         check("no irq", 0, 0, irq_o);
         check("data enable", k, k, rx_data_en_o);
      end
      // too few false wakes steer the threshold down to the energy level
      @(posedge clock_i);
      energy <= 8'h7c;
      wr(IDX_AUTO_TGT, 8'h01);
      wr(IDX_AUTO_WIN, 8'h01);
      repeat (400) @(posedge clock_i);
      wr(IDX_AUTO_WIN, 8'h00);
      host.access(1'b0, IDX_THRESH, 8'h00, rd);
      check("threshold", 8'h7c, 8'h7f, rd);
      wr(IDX_THRESH, THRESH_RST);
      // packet received after the identifier, select delayed by the coded bit times
      energy <= 8'hff;
      id_valid <= 1'b1;
      codes = '{0, 7, 1 + $urandom_range(5)};
      foreach (codes[i]) begin
         wr(IDX_IDLE_CFG, 8'(codes[i] << IC_DSEL_LO) | 8'h01);
         wr(IDX_COMMAND, CMD_IDLE_ENTER);
         pkt_valid <= 1'b1;
         for (t = 0; t < 500 && irq_o !== 1'b1; t++) @(posedge clock_i);
         pkt_valid <= 1'b0;
         bt_run <= 1'b1;
         check("irq", 1, 1, irq_o);
         n = 0;
         for (t = 0; t < 200; t++) begin
            @(posedge clock_i);
            #1;
            if (data_select_n_o === 1'b0) break;
            if (bit_tick === 1'b1) n++;
         end
         bt_run <= 1'b0;
         e = (codes[i] == 0) ? 0 : codes[i] + 1;
         check("select ticks", e, e, n);
         check("select", 0, 0, data_select_n_o);
         count_rise(1'b0, 64, n);
         check("host clock after packet", 1, 33, n);
         wr(IDX_COMMAND, CMD_IDLE_RETURN);
         repeat (4) @(posedge clock_i);
         check("irq cleared", 0, 0, irq_o);
      end
      report_and_stop();
   end
endmodule
